// File: verilog/core_addr_pkg.sv
package core_addr_pkg;

  // Data-space map of the special registers.
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_TIMER = 5'h01;
  localparam logic [4:0] ADDR_PC_LOW = 5'h02;
  localparam logic [4:0] ADDR_FLAGS = 5'h03;
  localparam logic [4:0] ADDR_POINTER = 5'h04;
  localparam logic [4:0] ADDR_PORT_A = 5'h05;
  localparam logic [4:0] ADDR_PORT_B = 5'h06;
  localparam logic [4:0] ADDR_RAM_BASE = 5'h07;

  // Sizes of the data space and its general RAM.
  localparam int DATA_SPACE_BYTES = 32;
  localparam int RAM_BYTES = 25;
  localparam int RAM_AW = 5;

  // Program store geometry.
  localparam int PC_W_LARGE = 10;
  localparam int PC_W_SMALL = 9;
  localparam int INSTR_W = 12;
  localparam int STACK_DEPTH = 2;

  // Flags register field positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_PD = 3;
  localparam int FLAG_TO = 4;
  localparam int FLAG_PAGE = 5;

  // Reset values.
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] OPTION_RESET = 8'h3F;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [4:0] POINTER_RESET = 5'h00;
  localparam logic [2:0] POINTER_HI_READ = 3'h7;
  localparam logic [3:0] PORT_A_HI_READ = 4'h0;
  localparam logic [1:0] FLAGS_HI_READ = 2'h0;
  localparam logic [7:0] INDIRECT_SELF_READ = 8'h00;

  // Program-counter commands from the fetch/execute pipeline.
  typedef enum logic [2:0] {
    PC_HOLD = 3'b000,
    PC_STEP = 3'b001,
    PC_GOTO = 3'b010,
    PC_CALL = 3'b011,
    PC_RET = 3'b100
  } pc_cmd_t;

  // One data-space access from the execute stage.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } data_req_t;

  // Arithmetic flag results; each write enable marks a flag the ALU owns.
  typedef struct packed {
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic z;
    logic dc;
    logic c;
  } alu_flags_t;

endpackage

// File: verilog/data_ram.sv
`timescale 1ns/1ns
// General-purpose data RAM with a registered read port.
module data_ram #(
  parameter int AW = 5,
  parameter int DEPTH = 25
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // Write port.
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // Read port.
  input wire logic [AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem [DEPTH];

  // The array carries no reset, so RAM powers up with unknown contents.
  always_ff @(posedge core_clk_in) begin
    if (we_in && (int'(waddr_in) < DEPTH)) begin // Int compare: a full power-of-two depth stays whole.
      mem[waddr_in] <= wdata_in;
    end
  end

  // Registered read keeps the data output on a flip-flop.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else if (int'(raddr_in) < DEPTH) begin
      rdata_out <= mem[raddr_in];
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule // data_ram

// File: verilog/pc_stack_data_addressing.sv
`timescale 1ns/1ns
// Operation
// - Program store read-only, up to 1K 12-bit words.
// - Counter steps sequentially, wraps past top to zero.
// - Reset loads top address, the reset vector.
// - 32-byte map: 25 RAM plus seven specials.
// - Indirect location accesses address held in pointer.
// - Indirect access through itself reads 00H.
// - Pointer uses five bits; upper three read ones.
// - Timer count register mapped, cleared at reset.
// - Counter 10 or 9 bits; low byte mapped.
// - Calls and low-byte writes clear bit 8.
// - Goto takes bit 8 from instruction.
// - Page bit supplies top bit on large variant.
// - Two-entry return stack, counter-width entries.
// - Calls push, returns pop; oldest lost on overflow.
// - Extra pops repeat second level, which stays.
// - Stack reachable only through call and return.
// - Direction registers reset to all ones, unmapped.
// - Config register resets to 0011 1111.
// - Unimplemented flag and port A bits read zero.
// - Warm reset keeps timer, ports, pointer; low byte ones.
// - Any ALU flag update blocks writes to Z, DC and C; TO, PD read-only.
module pc_stack_data_addressing #(
  parameter bit LARGE = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic warm_reset_in,
  // Program-counter control from the pipeline.
  input wire core_addr_pkg::pc_cmd_t pc_cmd_in,
  input wire logic [8:0] branch_lit_in,
  output logic [core_addr_pkg::PC_W_LARGE-1:0] prog_addr_out,
  // Data-space access.
  input wire core_addr_pkg::data_req_t data_req_in,
  input wire core_addr_pkg::alu_flags_t alu_flags_in,
  output logic [7:0] rdata_out,
  // Status inputs owned by the watchdog and sleep logic.
  input wire logic timeout_flag_in,
  input wire logic powerdown_flag_in,
  // Timer and unmapped configuration writes.
  input wire logic timer_tick_in,
  input wire logic pin_direction_a_wr_in,
  input wire logic pin_direction_b_wr_in,
  input wire logic option_wr_in,
  input wire logic [7:0] cfg_wdata_in,
  // Register contents towards the peripherals.
  output logic [7:0] timer_count_out,
  output logic [3:0] port_a_data_out,
  output logic [7:0] port_b_data_out,
  output logic [7:0] pin_direction_a_out,
  output logic [7:0] pin_direction_b_out,
  output logic [7:0] timer_prescale_config_out
);

  localparam int PC_W = LARGE ? core_addr_pkg::PC_W_LARGE : core_addr_pkg::PC_W_SMALL;
  localparam logic [PC_W-1:0] PC_TOP = {PC_W{1'b1}};

  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] stack1_r;
  logic [PC_W-1:0] stack2_r;
  logic page_r;
  logic zero_r;
  logic half_carry_r;
  logic carry_r;
  logic [4:0] pointer_r;
  logic [7:0] timer_count_r;
  logic [3:0] port_a_r;
  logic [7:0] port_b_r;
  logic [7:0] dir_a_r;
  logic [7:0] dir_b_r;
  logic [7:0] option_r;
  logic [7:0] sfr_q_r;
  logic ram_sel_r;
  logic [7:0] ram_q;
  logic [4:0] eff_addr;
  logic self_ref;
  logic wr_ok;
  logic pc_low_wr;
  logic flag_wr;
  logic [9:0] tgt;

  // Does an address hit general RAM rather than a special register?
  function automatic logic is_ram(input logic [4:0] a);
    return a >= core_addr_pkg::ADDR_RAM_BASE;
  endfunction

  // Write strobe for one special register.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_a);
    return wr_ok && (a == reg_a);
  endfunction

  // The indirect location has no storage; it redirects to the pointer.
  always_comb begin
    if (data_req_in.addr == core_addr_pkg::ADDR_INDIRECT) begin
      eff_addr = pointer_r;
    end else begin
      eff_addr = data_req_in.addr;
    end
    self_ref = (eff_addr == core_addr_pkg::ADDR_INDIRECT);
    wr_ok = data_req_in.wr && !self_ref;
    pc_low_wr = hit(eff_addr, core_addr_pkg::ADDR_PC_LOW);
    flag_wr = hit(eff_addr, core_addr_pkg::ADDR_FLAGS) &&
      !(alu_flags_in.upd_z || alu_flags_in.upd_dc || alu_flags_in.upd_c);
  end

  // Branch targets; the page bit only feeds them on the large variant.
  always_comb begin
    tgt = {LARGE & page_r, 9'h000};
    pc_nxt = pc_r;
    if (pc_low_wr) begin
      tgt[8:0] = {1'b0, data_req_in.wdata};
      pc_nxt = tgt[PC_W-1:0];
    end else begin
      case (pc_cmd_in)
        core_addr_pkg::PC_STEP: pc_nxt = pc_r + 1'b1;
        core_addr_pkg::PC_GOTO: begin
          tgt[8:0] = branch_lit_in;
          pc_nxt = tgt[PC_W-1:0];
        end
        core_addr_pkg::PC_CALL: begin
          tgt[8:0] = {1'b0, branch_lit_in[7:0]};
          pc_nxt = tgt[PC_W-1:0];
        end
        core_addr_pkg::PC_RET: pc_nxt = stack1_r;
        core_addr_pkg::PC_HOLD: pc_nxt = pc_r;
        default: pc_nxt = pc_r;
      endcase
    end
  end

  // Program counter; both resets restart at the top word.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_r <= PC_TOP;
    end else if (warm_reset_in) begin
      pc_r <= PC_TOP;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // The program store is read-only; only its address leaves here.
  always_comb begin
    prog_addr_out = '0;
    prog_addr_out[PC_W-1:0] = pc_r;
  end

  // Return stack: no data-space path reaches these registers.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stack1_r <= '0;
      stack2_r <= '0;
    end else if (!warm_reset_in && !pc_low_wr) begin
      if (pc_cmd_in == core_addr_pkg::PC_CALL) begin
        stack2_r <= stack1_r;
        stack1_r <= pc_r;
      end else if (pc_cmd_in == core_addr_pkg::PC_RET) begin
        stack1_r <= stack2_r;
      end
    end
  end

  // Flags: any ALU flag update blocks the data write to all three; TO and PD are inputs.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_r <= 1'b0;
      zero_r <= 1'b0;
      half_carry_r <= 1'b0;
      carry_r <= 1'b0;
    end else if (warm_reset_in) begin
      page_r <= 1'b0;
    end else begin
      if (hit(eff_addr, core_addr_pkg::ADDR_FLAGS)) begin
        page_r <= data_req_in.wdata[core_addr_pkg::FLAG_PAGE];
      end
      if (alu_flags_in.upd_z) begin
        zero_r <= alu_flags_in.z;
      end else if (flag_wr) begin
        zero_r <= data_req_in.wdata[core_addr_pkg::FLAG_Z];
      end
      if (alu_flags_in.upd_dc) begin
        half_carry_r <= alu_flags_in.dc;
      end else if (flag_wr) begin
        half_carry_r <= data_req_in.wdata[core_addr_pkg::FLAG_DC];
      end
      if (alu_flags_in.upd_c) begin
        carry_r <= alu_flags_in.c;
      end else if (flag_wr) begin
        carry_r <= data_req_in.wdata[core_addr_pkg::FLAG_C];
      end
    end
  end

  // Pointer keeps its value across a warm reset.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pointer_r <= core_addr_pkg::POINTER_RESET;
    end else if (!warm_reset_in && hit(eff_addr, core_addr_pkg::ADDR_POINTER)) begin
      pointer_r <= data_req_in.wdata[4:0];
    end
  end

  // Timer count: a software write wins over a tick in the same cycle.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer_count_r <= core_addr_pkg::TIMER_RESET;
    end else if (warm_reset_in) begin
      timer_count_r <= timer_count_r;
    end else if (hit(eff_addr, core_addr_pkg::ADDR_TIMER)) begin
      timer_count_r <= data_req_in.wdata;
    end else if (timer_tick_in) begin
      timer_count_r <= timer_count_r + 8'h01;
    end
  end

  // Port data latches survive a warm reset.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_a_r <= core_addr_pkg::PORT_RESET[3:0];
      port_b_r <= core_addr_pkg::PORT_RESET;
    end else if (!warm_reset_in) begin
      if (hit(eff_addr, core_addr_pkg::ADDR_PORT_A)) begin
        port_a_r <= data_req_in.wdata[3:0];
      end
      if (hit(eff_addr, core_addr_pkg::ADDR_PORT_B)) begin
        port_b_r <= data_req_in.wdata;
      end
    end
  end

  // Unmapped direction and config registers; every reset restores them.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dir_a_r <= core_addr_pkg::DIR_RESET;
      dir_b_r <= core_addr_pkg::DIR_RESET;
      option_r <= core_addr_pkg::OPTION_RESET;
    end else if (warm_reset_in) begin
      dir_a_r <= core_addr_pkg::DIR_RESET;
      dir_b_r <= core_addr_pkg::DIR_RESET;
      option_r <= core_addr_pkg::OPTION_RESET;
    end else begin
      if (pin_direction_a_wr_in) begin
        dir_a_r <= cfg_wdata_in;
      end
      if (pin_direction_b_wr_in) begin
        dir_b_r <= cfg_wdata_in;
      end
      if (option_wr_in) begin
        option_r <= cfg_wdata_in;
      end
    end
  end

  // Special-register read data, registered to line up with the RAM.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sfr_q_r <= 8'h00;
      ram_sel_r <= 1'b0;
    end else begin
      ram_sel_r <= data_req_in.rd && is_ram(eff_addr);
      case (eff_addr)
        core_addr_pkg::ADDR_INDIRECT: sfr_q_r <= core_addr_pkg::INDIRECT_SELF_READ;
        core_addr_pkg::ADDR_TIMER: sfr_q_r <= timer_count_r;
        core_addr_pkg::ADDR_PC_LOW: sfr_q_r <= pc_r[7:0];
        core_addr_pkg::ADDR_FLAGS: sfr_q_r <= {core_addr_pkg::FLAGS_HI_READ, page_r,
          timeout_flag_in, powerdown_flag_in, zero_r, half_carry_r, carry_r};
        core_addr_pkg::ADDR_POINTER: sfr_q_r <= {core_addr_pkg::POINTER_HI_READ,
          pointer_r};
        core_addr_pkg::ADDR_PORT_A: sfr_q_r <= {core_addr_pkg::PORT_A_HI_READ,
          port_a_r};
        core_addr_pkg::ADDR_PORT_B: sfr_q_r <= port_b_r;
        default: sfr_q_r <= 8'h00;
      endcase
    end
  end

  // General RAM behind the specials; index is the data address.
  data_ram #(
    .AW(core_addr_pkg::RAM_AW),
    .DEPTH(core_addr_pkg::DATA_SPACE_BYTES)
  ) u_ram (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .we_in(wr_ok && is_ram(eff_addr)),
    .waddr_in(eff_addr),
    .wdata_in(data_req_in.wdata),
    .raddr_in(eff_addr),
    .rdata_out(ram_q)
  );

  // Both read sources are flip-flops; this only picks between them.
  assign rdata_out = ram_sel_r ? ram_q : sfr_q_r;
  assign timer_count_out = timer_count_r;
  assign port_a_data_out = port_a_r;
  assign port_b_data_out = port_b_r;
  assign pin_direction_a_out = dir_a_r;
  assign pin_direction_b_out = dir_b_r;
  assign timer_prescale_config_out = option_r;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic plain_cycle;
  assign plain_cycle = !warm_reset_in && !pc_low_wr;

  property p_pc_wrap;
    plain_cycle && pc_cmd_in == core_addr_pkg::PC_STEP && pc_r == PC_TOP |=> pc_r == '0;
  endproperty
  a_pc_wrap: assert property (p_pc_wrap) else $error("Counter did not wrap to zero.");

  property p_warm_top;
    warm_reset_in |=> pc_r == PC_TOP && pin_direction_a_out == core_addr_pkg::DIR_RESET;
  endproperty
  a_warm_top: assert property (p_warm_top) else $error("Warm reset missed top address.");

  property p_indirect_self;
    data_req_in.rd && data_req_in.addr == core_addr_pkg::ADDR_INDIRECT &&
      pointer_r == core_addr_pkg::ADDR_INDIRECT |=> rdata_out == 8'h00;
  endproperty
  a_indirect_self: assert property (p_indirect_self) else $error("Self read not zero.");

  property p_pointer_hi;
    data_req_in.rd && eff_addr == core_addr_pkg::ADDR_POINTER |=> rdata_out[7:5] == 3'h7;
  endproperty
  a_pointer_hi: assert property (p_pointer_hi) else $error("Pointer top bits not ones.");

  property p_call_push;
    plain_cycle && pc_cmd_in == core_addr_pkg::PC_CALL |=>
      stack1_r == $past(pc_r) && stack2_r == $past(stack1_r) && pc_r[8] == 1'b0;
  endproperty
  a_call_push: assert property (p_call_push) else $error("Call push wrong.");

  property p_ret_pop;
    plain_cycle && pc_cmd_in == core_addr_pkg::PC_RET |=>
      pc_r == $past(stack1_r) && stack2_r == $past(stack2_r) && stack1_r == stack2_r;
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("Return pop wrong.");

  property p_goto;
    plain_cycle && pc_cmd_in == core_addr_pkg::PC_GOTO |=>
      pc_r[8:0] == $past(branch_lit_in);
  endproperty
  a_goto: assert property (p_goto) else $error("Goto target wrong.");

  property p_flag_guard;
    alu_flags_in.upd_z && !warm_reset_in ##1 1'b1 |-> zero_r == $past(alu_flags_in.z);
  endproperty
  a_flag_guard: assert property (p_flag_guard) else $error("ALU zero flag lost.");

  property p_pcl_write;
    !warm_reset_in && pc_low_wr |=> pc_r[8:0] == {1'b0, $past(data_req_in.wdata)};
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("Low-byte write wrong.");

  c_wrap: cover property (pc_r == PC_TOP ##1 pc_r == '0);
  c_self_read: cover property (data_req_in.rd && self_ref);
  c_call_ret: cover property (pc_cmd_in == core_addr_pkg::PC_CALL ##[1:8]
    pc_cmd_in == core_addr_pkg::PC_RET);
  c_deep_call: cover property (pc_cmd_in == core_addr_pkg::PC_CALL ##1
    pc_cmd_in == core_addr_pkg::PC_CALL ##1 pc_cmd_in == core_addr_pkg::PC_CALL);

endmodule // pc_stack_data_addressing

// File: dv/prog_store_model.sv
`timescale 1ns/1ns
// Program store seen from the fetch stage; a fixed table that nothing can write.
module prog_store_model #(
  parameter int DEPTH = 1024
) (
  // Fetch address.
  input wire logic [core_addr_pkg::PC_W_LARGE-1:0] addr_in,
  // Instruction word.
  output logic [core_addr_pkg::INSTR_W-1:0] word_out
);
  // Contents follow the address, so a wrong fetch address shows in the word.
  always_comb begin
    word_out = (int'(addr_in) < DEPTH) ? ({2'h0, addr_in} ^ 12'hA5A) : 12'hFFF;
  end
endmodule // prog_store_model

// File: dv/pc_stack_data_addressing_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch at %0t got %0h expected %0h", $time, got, exp); end end
module pc_stack_data_addressing_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic warm = 1'b0;
  core_addr_pkg::pc_cmd_t pc_cmd = core_addr_pkg::PC_HOLD;
  logic [8:0] lit = 9'h000;
  core_addr_pkg::data_req_t req = '0;
  core_addr_pkg::alu_flags_t alu = '0;
  logic to_f = 1'b1;
  logic pd_f = 1'b1;
  logic tick = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [9:0] pc;
  logic [7:0] rdata, tmr, pb, da, db, opt, pbv, mon_exp;
  logic [3:0] pa;
  logic [11:0] word;
  logic [7:0] exp_q[$];
  logic [7:0] ram_exp[32];
  logic rd_seen = 1'b0;
  int miscompares = 0;
  int n_compared = 0;

  pc_stack_data_addressing #(.LARGE(1'b1)) dut (
    .core_clk_in(core_clk), .rstn_in(rstn), .warm_reset_in(warm),
    .pc_cmd_in(pc_cmd), .branch_lit_in(lit), .prog_addr_out(pc),
    .data_req_in(req), .alu_flags_in(alu), .rdata_out(rdata),
    .timeout_flag_in(to_f), .powerdown_flag_in(pd_f), .timer_tick_in(tick),
    .pin_direction_a_wr_in(cfg_wr), .pin_direction_b_wr_in(cfg_wr), .option_wr_in(cfg_wr),
    .cfg_wdata_in(cfg), .timer_count_out(tmr), .port_a_data_out(pa), .port_b_data_out(pb),
    .pin_direction_a_out(da), .pin_direction_b_out(db), .timer_prescale_config_out(opt)
  );
  prog_store_model #(.DEPTH(1024)) rom (.addr_in(pc), .word_out(word));

  // Free-running core clock.
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // Read data lands one cycle after the read; compare it mid-cycle when settled.
  always @(posedge core_clk) rd_seen <= req.rd & rstn & ~warm;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("mismatch at %0t got %0h expected none", $time, rdata);
      end else begin
        mon_exp = exp_q.pop_front();
        `CHK(rdata, mon_exp)
      end
    end
  end

  // Drive one cycle just after the edge and hold it through the next edge.
  task automatic cyc(input core_addr_pkg::pc_cmd_t c, input logic [8:0] l, input logic r,
                     input logic w, input logic [4:0] a, input logic [7:0] d);
    pc_cmd = c;
    lit = l;
    req = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cyc(core_addr_pkg::PC_HOLD, 9'h000, 1'b0, 1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cyc(core_addr_pkg::PC_HOLD, 9'h000, 1'b1, 1'b0, a, 8'h00);
  endtask
  task automatic idle();
    cyc(core_addr_pkg::PC_HOLD, 9'h000, 1'b0, 1'b0, 5'h00, 8'h00);
  endtask
  task automatic pcc(input core_addr_pkg::pc_cmd_t c, input logic [8:0] l, input logic [9:0] e);
    cyc(c, l, 1'b0, 1'b0, 5'h00, 8'h00);
    `CHK(pc, e)
  endtask

  // The verdict is printed in one place only, whoever ends the run.
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the 125 or so cycles the sequence needs.
  initial begin
    #40000;
    miscompares++;
    $display("watchdog expired");
    print_verdict();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h1a62c14e));
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    `CHK(pc, 10'h3FF)
    `CHK(word, 12'h3FF ^ 12'hA5A)
    `CHK({da, db}, 16'hFFFF)
    `CHK(opt, 8'h3F)
    `CHK(tmr, 8'h00)
    rd(core_addr_pkg::ADDR_PC_LOW, 8'hFF);
    pcc(core_addr_pkg::PC_STEP, 9'h000, 10'h000);
    pcc(core_addr_pkg::PC_STEP, 9'h000, 10'h001);
    pcc(core_addr_pkg::PC_GOTO, 9'h1A5, 10'h1A5);
    $display("test reset_step_goto done");
    // Z owned by the ALU this cycle, so the data write must not reach it.
    alu = '{upd_z: 1'b1, upd_dc: 1'b0, upd_c: 1'b0, z: 1'b0, dc: 1'b0, c: 1'b0};
    wr(core_addr_pkg::ADDR_FLAGS, 8'hE7);
    alu = '0;
    rd(core_addr_pkg::ADDR_FLAGS, 8'h38);
    pcc(core_addr_pkg::PC_GOTO, 9'h055, 10'h255);
    pcc(core_addr_pkg::PC_CALL, 9'h1C3, 10'h2C3);
    cyc(core_addr_pkg::PC_GOTO, 9'h011, 1'b0, 1'b1, core_addr_pkg::ADDR_PC_LOW, 8'h77);
    `CHK(pc, 10'h277)
    rd(core_addr_pkg::ADDR_PC_LOW, 8'h77);
    wr(core_addr_pkg::ADDR_FLAGS, 8'h07);
    rd(core_addr_pkg::ADDR_FLAGS, 8'h1F);
    $display("test page_flags done");
    pcc(core_addr_pkg::PC_GOTO, 9'h100, 10'h100);
    pcc(core_addr_pkg::PC_CALL, 9'h011, 10'h011);
    pcc(core_addr_pkg::PC_CALL, 9'h022, 10'h022);
    pcc(core_addr_pkg::PC_CALL, 9'h033, 10'h033);
    // Fill all of RAM while calls are pending; none of it may touch the stack.
    for (int a = 7; a < 32; a++) begin
      ram_exp[a] = 8'($urandom);
      wr(5'(a), ram_exp[a]);
    end
    for (int a = 7; a < 32; a++) begin
      wr(core_addr_pkg::ADDR_POINTER, 8'(a));
      rd(core_addr_pkg::ADDR_INDIRECT, ram_exp[a]);
    end
    pcc(core_addr_pkg::PC_RET, 9'h000, 10'h022);
    pcc(core_addr_pkg::PC_RET, 9'h000, 10'h011);
    pcc(core_addr_pkg::PC_RET, 9'h000, 10'h011);
    pcc(core_addr_pkg::PC_RET, 9'h000, 10'h011);
    $display("test stack_ram done");
    wr(core_addr_pkg::ADDR_POINTER, 8'h0A);
    rd(core_addr_pkg::ADDR_POINTER, 8'hEA);
    wr(core_addr_pkg::ADDR_INDIRECT, 8'h5C);
    rd(5'h0A, 8'h5C);
    wr(core_addr_pkg::ADDR_POINTER, 8'hE0);
    wr(core_addr_pkg::ADDR_INDIRECT, 8'hAA);
    rd(core_addr_pkg::ADDR_INDIRECT, 8'h00);
    rd(core_addr_pkg::ADDR_POINTER, 8'hE0);
    wr(core_addr_pkg::ADDR_POINTER, 8'h0A);
    $display("test indirect done");
    wr(core_addr_pkg::ADDR_PORT_A, 8'hFF);
    rd(core_addr_pkg::ADDR_PORT_A, 8'h0F);
    `CHK(pa, 4'hF)
    pbv = 8'($urandom);
    wr(core_addr_pkg::ADDR_PORT_B, pbv);
    rd(core_addr_pkg::ADDR_PORT_B, pbv);
    `CHK(pb, pbv)
    wr(core_addr_pkg::ADDR_TIMER, 8'h10);
    tick = 1'b1;
    idle();
    tick = 1'b0;
    rd(core_addr_pkg::ADDR_TIMER, 8'h11);
    cfg = 8'h5A;
    cfg_wr = 1'b1;
    idle();
    cfg_wr = 1'b0;
    `CHK({da, db, opt}, 24'h5A5A5A)
    $display("test ports_timer_cfg done");
    warm = 1'b1;
    idle();
    warm = 1'b0;
    `CHK(pc, 10'h3FF)
    `CHK({da, db, opt}, 24'hFFFF3F)
    `CHK(tmr, 8'h11)
    rd(core_addr_pkg::ADDR_PC_LOW, 8'hFF);
    rd(core_addr_pkg::ADDR_POINTER, 8'hEA);
    rd(core_addr_pkg::ADDR_PORT_B, pbv);
    pcc(core_addr_pkg::PC_STEP, 9'h000, 10'h000);
    rstn = 1'b0;
    idle();
    rstn = 1'b1;
    `CHK(tmr, 8'h00)
    `CHK(pc, 10'h3FF)
    idle();
    $display("test warm_and_cold_reset done");
    print_verdict();
  end
endmodule // pc_stack_data_addressing_tb_top
